// File: verilog/rri_pkg.sv
// Shared constants and carrier types for the read recovery idle inserter.
`default_nettype none

package rri_pkg;

  // Idle control register layout and reset value.
  localparam logic [15:0] BUS_IDLE_CTRL_RESET = 16'hfff0;
  localparam int          PAIR1_IDLE_LSB      = 10;
  localparam int          PAIR0_IDLE_LSB      = 8;
  localparam int          PAIR1_CONT_BIT      = 5;
  localparam int          PAIR0_CONT_BIT      = 4;

  // Idle gap counter width and its saturation value.
  localparam int          GAP_W               = 2;
  localparam logic [1:0]  GAP_MAX             = 2'h3;
  localparam logic [1:0]  GAP_NONE            = 2'h0;

  // Chip-select codes.
  localparam logic [7:0]  CS_ALL_OFF          = 8'hff;
  localparam logic [7:0]  CS_ONE_HOT          = 8'h01;

  // One access request from the bus controller core.
  typedef struct packed {
    logic       write;                   // High for a write, low for a read.
    logic [2:0] space;                   // Chip-select space number 0 to 7.
  } rri_acc_s;

endpackage : rri_pkg

`default_nettype wire

// File: verilog/rri_gap_counter.sv
// Saturating counter of idle cycles since the last bus access.
`timescale 1ns/100ps
`default_nettype none

module rri_gap_counter #(
  parameter int W = 2
) (
  input  wire logic         i_mclk,      // System bus clock.
  input  wire logic         i_rst,       // Synchronous reset, active high.
  input  wire logic         i_clear,     // Restart counting at zero.
  output logic      [W-1:0] o_count      // Cycles elapsed, saturating.
);

  // Count saturates so a long quiet bus needs no further idle cycles.
  always_ff @(posedge i_mclk) begin
    if (i_rst || i_clear) begin
      o_count <= i_rst ? {W{1'b1}} : '0;
    end else if (o_count != {W{1'b1}}) begin
      o_count <= o_count + 1'b1;
    end
  end

endmodule : rri_gap_counter

`default_nettype wire

// File: verilog/read_recovery_idle_inserter.sv
// Inserts idle cycles after reads to chip-select spaces 1/5 and 0/4.
// Functional notes
// RQ1: After pair1 read, idle before pair1 write.
// RQ2: After pair1 read, idle before other spaces.
// RQ3: Pair1 setting value is the idle count.
// RQ4: After pair0 read, idle before pair0 write.
// RQ5: After pair0 read, idle before other spaces.
// RQ6: Pair0 setting value is the idle count.
// RQ7: Idle setting bits reset to one, read/write.
// RQ8: Read then write uses larger idle setting.
// RQ9: Settings live in 16-bit control register.
// RQ10: No access, chip selects negated during idle.
`timescale 1ns/100ps
`default_nettype none

module read_recovery_idle_inserter (
  input  wire logic              i_mclk,                 // System bus clock, 100 MHz.
  input  wire logic              i_rst,                  // Synchronous reset, active high.
  input  wire logic              i_bus_idle_control_wr,  // Write strobe for control register.
  input  wire logic [15:0]       i_bus_idle_control_wdata, // Write data for control register.
  input  wire logic              i_acc_req,              // Access request, held until granted.
  input  wire rri_pkg::rri_acc_s i_acc,                  // Space and direction of the request.
  output logic      [15:0]       o_bus_idle_control_reg, // Control register contents.
  output logic                   o_acc_grant,            // Access cycle in progress.
  output logic      [7:0]        o_cs_n,                 // Chip selects, active low.
  output logic                   o_idle                  // Pending request held off.
);

  logic              last_valid;
  rri_pkg::rri_acc_s last_acc;
  logic [1:0]        gap;

  // Settings belonging to the space pair of the previous access.
  wire [1:0] pair1_idle = o_bus_idle_control_reg[rri_pkg::PAIR1_IDLE_LSB +: 2];
  wire [1:0] pair0_idle = o_bus_idle_control_reg[rri_pkg::PAIR0_IDLE_LSB +: 2];
  wire       pair1_cont = o_bus_idle_control_reg[rri_pkg::PAIR1_CONT_BIT];
  wire       pair0_cont = o_bus_idle_control_reg[rri_pkg::PAIR0_CONT_BIT];
  // RQ3 RQ6 direct count decode
  wire [1:0] last_iw    = last_acc.space[0] ? pair1_idle : pair0_idle;
  wire [1:0] last_cw    = {1'b0, (last_acc.space[0] ? pair1_cont : pair0_cont)};

  // Classification of the pending request against the previous access.
  wire       last_handled = last_valid && !last_acc.space[1];
  wire       last_read    = last_handled && !last_acc.write;
  wire       same_pair    = last_acc.space[1:0] == i_acc.space[1:0];
  // RQ8 larger setting wins
  wire [1:0] iw_or_cw     = (last_iw >= last_cw) ? last_iw : last_cw;

  // Idle cycles owed before the pending request may start.
  wire [1:0] need_after_read  = !same_pair ? last_iw : (i_acc.write ? iw_or_cw : last_cw);
  wire [1:0] need_after_write = same_pair ? last_cw : rri_pkg::GAP_NONE;
  // RQ1 RQ2 RQ4 RQ5 read recovery need
  wire [1:0] need = !last_handled ? rri_pkg::GAP_NONE :
                    (last_read ? need_after_read : need_after_write);

  // RQ10 hold off start
  wire       start  = i_acc_req && (gap >= need);
  wire [7:0] cs_sel = ~(rri_pkg::CS_ONE_HOT << i_acc.space);

  // Idle cycles counted from the access cycle onward.
  rri_gap_counter #(
    .W (rri_pkg::GAP_W)
  ) rri_gap_counter_inst (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_clear (start),
    .o_count (gap)
  );

  // RQ7 RQ9 control register
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_bus_idle_control_reg <= rri_pkg::BUS_IDLE_CTRL_RESET;
    end else if (i_bus_idle_control_wr) begin
      o_bus_idle_control_reg <= i_bus_idle_control_wdata;
    end
  end

  // Remember the kind and space of the access being started.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      last_valid <= 1'b0;
      last_acc   <= '0;
    end else if (start) begin
      last_valid <= 1'b1;
      last_acc   <= i_acc;
    end
  end

  // RQ10 negate selects when idle
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_acc_grant <= 1'b0;
      o_cs_n      <= rri_pkg::CS_ALL_OFF;
      o_idle      <= 1'b0;
    end else begin
      o_acc_grant <= start;
      o_cs_n      <= start ? cs_sel : rri_pkg::CS_ALL_OFF;
      o_idle      <= i_acc_req && !start;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // A pair1 write after a pair1 read waits the programmed count.
  property p_rq1;
    start && last_read && last_acc.space[0] && same_pair && i_acc.write |-> gap >= pair1_idle;
  endproperty
  a_rq1: assert property (p_rq1) else $error("pair1 write started too soon after read"); // RQ1

  // Any other space after a pair1 read waits the programmed count.
  property p_rq2;
    start && last_read && last_acc.space[0] && !same_pair |-> gap >= pair1_idle;
  endproperty
  a_rq2: assert property (p_rq2) else $error("other space started too soon after pair1 read"); // RQ2

  // Setting three gives three idle cycles before a pair1 write.
  property p_rq3;
    (o_acc_grant && !o_cs_n[1] && !last_acc.write && pair1_idle == 2'h3 && !i_bus_idle_control_wr)
      ##1 (i_acc_req && i_acc.write && i_acc.space == 3'h5 && !i_bus_idle_control_wr)
      |-> (o_cs_n == 8'hff) [*3] ##1 !o_cs_n[5];
  endproperty
  a_rq3: assert property (p_rq3) else $error("pair1 idle count of three not honoured"); // RQ3

  // A pair0 write after a pair0 read waits the programmed count.
  property p_rq4;
    start && last_read && !last_acc.space[0] && same_pair && i_acc.write |-> gap >= pair0_idle;
  endproperty
  a_rq4: assert property (p_rq4) else $error("pair0 write started too soon after read"); // RQ4

  // Any other space after a pair0 read waits the programmed count.
  property p_rq5;
    start && last_read && !last_acc.space[0] && !same_pair |-> gap >= pair0_idle;
  endproperty
  a_rq5: assert property (p_rq5) else $error("other space started too soon after pair0 read"); // RQ5

  // Setting two gives exactly two idle cycles before another space.
  property p_rq6;
    (o_acc_grant && !o_cs_n[0] && !last_acc.write && pair0_idle == 2'h2 && !i_bus_idle_control_wr)
      ##1 (i_acc_req && i_acc.space == 3'h2 && !i_bus_idle_control_wr)
      |-> (o_cs_n == 8'hff) [*2] ##1 !o_cs_n[2];
  endproperty
  a_rq6: assert property (p_rq6) else $error("pair0 idle count of two not honoured"); // RQ6

  // Idle settings come out of reset all ones.
  property p_rq7;
    $fell(i_rst) |-> o_bus_idle_control_reg[11:8] == 4'hf;
  endproperty
  a_rq7: assert property (p_rq7) else $error("idle settings not reset to ones"); // RQ7

  // A write after a read in the same pair also honours the continuous setting.
  property p_rq8;
    start && last_read && same_pair && i_acc.write |-> gap >= last_cw && gap >= last_iw;
  endproperty
  a_rq8: assert property (p_rq8) else $error("write after read ignored larger setting"); // RQ8

  // Software writes land in the control register on the next cycle.
  property p_rq9;
    i_bus_idle_control_wr |=> o_bus_idle_control_reg == $past(i_bus_idle_control_wdata);
  endproperty
  a_rq9: assert property (p_rq9) else $error("control register write lost"); // RQ9

  // While a request is held off every chip select stays negated.
  property p_rq10;
    o_idle |-> o_cs_n == 8'hff && !o_acc_grant;
  endproperty
  a_rq10: assert property (p_rq10) else $error("chip select asserted during idle"); // RQ10

  // Setting two gives exactly two idle cycles before a foreign space.
  property p_rq2_two;
    (o_acc_grant && !o_cs_n[1] && !last_acc.write && pair1_idle == 2'h2 && !i_bus_idle_control_wr)
      ##1 (i_acc_req && i_acc.space == 3'h6 && !i_bus_idle_control_wr)
      |-> (o_cs_n == rri_pkg::CS_ALL_OFF) [*2] ##1 !o_cs_n[6];
  endproperty
  a_rq2_two: assert property (p_rq2_two) else $error("pair1 idle count of two not honoured"); // RQ2

  // Setting one gives a single idle cycle before a pair1 write.
  property p_rq3_one;
    (o_acc_grant && !o_cs_n[1] && !last_acc.write && pair1_idle == 2'h1 && !i_bus_idle_control_wr)
      ##1 (i_acc_req && i_acc.write && i_acc.space == 3'h5 && !i_bus_idle_control_wr)
      |-> (o_cs_n == rri_pkg::CS_ALL_OFF) ##1 !o_cs_n[5];
  endproperty
  a_rq3_one: assert property (p_rq3_one) else $error("pair1 idle count of one not honoured"); // RQ3

  // Setting three gives three idle cycles before a pair0 write.
  property p_rq6_three;
    (o_acc_grant && !o_cs_n[4] && !last_acc.write && pair0_idle == 2'h3 && !i_bus_idle_control_wr)
      ##1 (i_acc_req && i_acc.write && i_acc.space == 3'h4 && !i_bus_idle_control_wr)
      |-> (o_cs_n == rri_pkg::CS_ALL_OFF) [*3] ##1 !o_cs_n[4];
  endproperty
  a_rq6_three: assert property (p_rq6_three) else $error("pair0 idle count of three lost"); // RQ6

  // The whole control word comes out of reset at its documented value.
  property p_rq7_full;
    $fell(i_rst) |-> o_bus_idle_control_reg == rri_pkg::BUS_IDLE_CTRL_RESET;
  endproperty
  a_rq7_full: assert property (p_rq7_full) else $error("control word reset value wrong"); // RQ7

  // Without a write strobe the control register keeps its contents.
  property p_rq9_hold;
    !i_bus_idle_control_wr |=> $stable(o_bus_idle_control_reg);
  endproperty
  a_rq9_hold: assert property (p_rq9_hold) else $error("control register changed unwritten"); // RQ9

  // A request that still owes idle cycles is held off and flagged.
  property p_rq10_held;
    i_acc_req && gap < need |=> !o_acc_grant && o_idle && o_cs_n == rri_pkg::CS_ALL_OFF;
  endproperty
  a_rq10_held: assert property (p_rq10_held) else $error("request started during idle"); // RQ10

  // An access cycle drives exactly one chip select.
  property p_rq10_onehot;
    o_acc_grant |-> $onehot(~o_cs_n);
  endproperty
  a_rq10_onehot: assert property (p_rq10_onehot) else $error("access without one select"); // RQ10

  // Outside access cycles every chip select stays negated.
  property p_rq10_quiet;
    !o_acc_grant |-> o_cs_n == rri_pkg::CS_ALL_OFF;
  endproperty
  a_rq10_quiet: assert property (p_rq10_quiet) else $error("select outside access cycle"); // RQ10

endmodule : read_recovery_idle_inserter

`default_nettype wire

// File: verif/rri_mem_model.sv
// Memory device model that measures deselected cycles between accesses.
`timescale 1ns/100ps
`default_nettype none

module rri_mem_model (
  input  wire logic       i_mclk,  // System bus clock.
  input  wire logic [7:0] i_cs_n,  // Chip selects, active low.
  output logic      [7:0] o_gap    // Deselected cycles before the current access.
);
  // deselect counting.
  // Restarts on every selected cycle and saturates so a long pause stays readable.
  always_ff @(posedge i_mclk) begin
    if (i_cs_n != 8'hff) o_gap <= 8'h00;
    else if (o_gap != 8'hff) o_gap <= o_gap + 8'h01;
  end
endmodule : rri_mem_model

`default_nettype wire

// File: verif/read_recovery_idle_inserter_bench.sv
// Self-checking bench for the read recovery idle inserter.
`timescale 1ns/100ps
`default_nettype none

module read_recovery_idle_inserter_bench;
  logic              mclk  = 1'b0;
  logic              rst   = 1'b1;
  logic              wr    = 1'b0;
  logic              req   = 1'b0;
  logic [15:0]       wdata = 16'h0000;
  rri_pkg::rri_acc_s acc   = '0;
  logic [15:0]       reg_q;
  logic              grant;
  logic              idle;
  logic [7:0]        cs_n;
  logic [7:0]        gap;
  logic [7:0]        exp_cs[$];
  logic [7:0]        exp_gap[$];
  logic [4:0]        prev  = 5'h00;
  int                bad_count = 0;
  int                checked   = 0;
  int                cycles    = 0;
  // Chain of {write, space}: read then write or read in pair, read then foreign space.
  logic [3:0]        seq[12] = '{4'h1, 4'hd, 4'h5, 4'h1, 4'h6, 4'h0,
                                 4'ha, 4'h4, 4'hc, 4'h8, 4'hb, 4'h1};

  always #5 mclk = ~mclk;

  read_recovery_idle_inserter read_recovery_idle_inserter_inst (
    .i_mclk(mclk), .i_rst(rst), .i_bus_idle_control_wr(wr), .i_bus_idle_control_wdata(wdata),
    .i_acc_req(req), .i_acc(acc), .o_bus_idle_control_reg(reg_q), .o_acc_grant(grant),
    .o_cs_n(cs_n), .o_idle(idle));

  rri_mem_model rri_mem_model_inst (.i_mclk(mclk), .i_cs_n(cs_n), .o_gap(gap));

  // Idle cycles owed between a previous access p and the next access n.
  function automatic logic [7:0] owed(logic [4:0] p, logic [3:0] n, logic [15:0] r);
    logic [1:0] iw;
    logic       cw;
    logic       same;
    iw   = r[rri_pkg::PAIR0_IDLE_LSB + 2 * p[0] +: 2];
    cw   = r[rri_pkg::PAIR0_CONT_BIT + p[0]];
    same = (n[1:0] == p[1:0]);
    if (!p[4] || p[1]) return 8'h00;
    if (p[3]) return same ? 8'(cw) : 8'h00;
    if (!same) return 8'(iw);
    if (n[3]) return (iw > 2'(cw)) ? 8'(iw) : 8'(cw);
    return 8'(cw);
  endfunction : owed

  task automatic compare(string what, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : compare

  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic write_reg(logic [15:0] d);
    wr    <= 1'b1;
    wdata <= d;
    @(posedge mclk);
    #1 wr <= 1'b0;
    @(posedge mclk);
    #1 compare("control register", d, reg_q);  // full word read back.
  endtask : write_reg

  // Notes the expected selects and gap, then holds the request until granted.
  task automatic access(logic [3:0] n, bit chained);
    int k;
    exp_cs.push_back(~(rri_pkg::CS_ONE_HOT << n[2:0]));
    exp_gap.push_back(chained ? owed(prev, n, reg_q) : 8'hff);
    acc <= rri_pkg::rri_acc_s'(n);
    req <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      #1 k++;
    end while (grant !== 1'b1 && k < 20);
    if (grant !== 1'b1) compare("grant", 16'h1, 16'(grant));  // request served.
    prev = {1'b1, n};
  endtask : access

  // Watches every cycle: selects only in grant cycles, idle flag after a held request.
  always @(posedge mclk) begin
    logic [7:0] g;
    logic       r;
    r = req;
    #2;
    if (grant === 1'b1) begin
      compare("chip selects", 16'(exp_cs.pop_front()), 16'(cs_n));  // one select.
      compare("idle flag", 16'h0, 16'(idle));  // not held off.
      g = exp_gap.pop_front();
      if (g != 8'hff) compare("idle gap", 16'(g), 16'(gap));
    end else begin
      compare("negated selects", 16'hff, 16'(cs_n));  // held off.
      compare("idle flag", 16'(r), 16'(idle));  // request held off.
    end
  end

  // Cuts a hang short.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      close_out();
    end
  end

  initial begin
    logic [15:0] d;
    void'($urandom(32));
    repeat (16) @(posedge mclk);
    #1 rst <= 1'b0;
    @(posedge mclk);
    #1 compare("reset value", rri_pkg::BUS_IDLE_CTRL_RESET, reg_q);  // bits 15:4 set.
    for (int t = 0; t < 5; t++) begin
      if (t > 0) begin
        d       = 16'($urandom);
        d[11:8] = {2'(t - 1), 2'(4 - t)};
        write_reg(d);  // every code.
      end
      for (int i = 0; i < 12; i++) access(seq[i], i > 0);
      req <= 1'b0;
      repeat (4) @(posedge mclk);
      #1 $display("Test %0d done", t);
    end
    compare("pending results", 16'h0, 16'(exp_cs.size()));  // every access served.
    close_out();
  end
endmodule : read_recovery_idle_inserter_bench

`default_nettype wire
